//--- rtl/accel_register_bank.sv
// register bank of a three-axis accelerometer, upper map plus self-test
// assumes serial port pins already synchronous to clk; mode 3 style port
// Contract
// - high/low register pairs give upper and lower bytes of one value
// - axis and temperature high byte is bits 15:8, low byte bits 7:0
// - registers not listed as exceptions, identity and queue registers aside, read zero after reset
// - primary power register at 107 resets to one
// - self-test registers 13 to 15 load factory values at reset
// - six bias trim registers load factory offset values at reset
// - first byte: top bit read when one, then seven-bit address
// - single and burst reads and writes, address steps per byte
`timescale 1ns/1ns
`default_nettype none
module accel_register_bank
  import accel_regs_pkg::*;
#(
  parameter logic [7:0] IDENTITY_VALUE = 8'h5a  // arbitrary value
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // serial port
  input  wire accel_regs_pkg::serial_in_t serial_in,
  output logic                         sdo_out,
  output logic                         sdo_oe_n,
  // sensor side
  input  wire accel_regs_pkg::sample_t  sample,
  input  wire logic                    sample_valid,
  input  wire logic [7:0]              event_flags,
  input  wire logic [12:0]             queue_level,
  input  wire logic [7:0]              queue_rd_data,
  input  wire accel_regs_pkg::factory_t factory,
  // control out
  output logic [7:0]                   int_mask_out,
  output logic [7:0]                   power_pri_out,
  output logic                         queue_rd_pulse,
  output logic                         queue_wr_pulse,
  output logic [7:0]                   queue_wr_data
);
  import accel_regs_pkg::*;

  // -----------------------------------------------------------------
  // serial framing
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10
  } frame_t;

  frame_t      state_q, state_d;
  logic        sclk_q, sclk_d;
  logic [2:0]  bit_q, bit_d;
  logic [7:0]  shift_q, shift_d;
  logic [6:0]  addr_q, addr_d;
  logic        read_q, read_d;
  logic [7:0]  tx_q, tx_d;
  logic        sdo_q, sdo_d;
  logic        oe_n_q, oe_n_d;
  logic        rise, fall, byte_done;
  logic        wr_stb, rd_stb;
  logic [7:0]  wr_val;

  assign rise      = serial_in.sclk & ~sclk_q;
  assign fall      = ~serial_in.sclk & sclk_q;
  assign byte_done = rise && bit_q == 3'h7;

  // -----------------------------------------------------------------
  // register state
  // -----------------------------------------------------------------
  logic [7:0] pin_q, mask_q, flags_q, path_q, motion_q, host_q;
  logic [7:0] pwr1_q, pwr2_q, selfx_q, selfy_q, selfz_q;
  logic [7:0] pin_d, mask_d, flags_d, path_d, motion_d, host_d;
  logic [7:0] pwr1_d, pwr2_d, selfx_d, selfy_d, selfz_d;
  logic [15:0] trimx_q, trimy_q, trimz_q, trimx_d, trimy_d, trimz_d;
  sample_t     data_q, data_d;
  sample_t     held_q, held_d;
  logic        fresh_q, fresh_d;
  logic        loaded_q, loaded_d;
  logic        qrd_q, qrd_d, qwr_q, qwr_d;
  logic [7:0]  qwd_q, qwd_d;

  // read mux: pairs share one value split by byte
  function automatic logic [7:0] read_reg(input logic [6:0] a);
    unique case (a)
      ADDR_SELF_TEST_X:  read_reg = selfx_q;
      ADDR_SELF_TEST_Y:  read_reg = selfy_q;
      ADDR_SELF_TEST_Z:  read_reg = selfz_q;
      ADDR_INT_PIN:      read_reg = pin_q;
      ADDR_INT_MASK:     read_reg = mask_q;
      ADDR_INT_FLAGS:    read_reg = flags_q;
      ADDR_ACCEL_X_HIGH: read_reg = data_q.x[15:8];
      ADDR_ACCEL_X_LOW:  read_reg = data_q.x[7:0];
      ADDR_ACCEL_Y_HIGH: read_reg = data_q.y[15:8];
      ADDR_ACCEL_Y_LOW:  read_reg = data_q.y[7:0];
      ADDR_ACCEL_Z_HIGH: read_reg = data_q.z[15:8];
      ADDR_ACCEL_Z_LOW:  read_reg = data_q.z[7:0];
      ADDR_TEMP_HIGH:    read_reg = data_q.temp[15:8];
      ADDR_TEMP_LOW:     read_reg = data_q.temp[7:0];
      ADDR_PATH_CLEAR:   read_reg = path_q;
      ADDR_MOTION_CTRL:  read_reg = motion_q;
      ADDR_HOST_CTRL:    read_reg = host_q;
      ADDR_POWER_PRI:    read_reg = pwr1_q;
      ADDR_POWER_STBY:   read_reg = pwr2_q;
      ADDR_QUEUE_HIGH:   read_reg = {3'h0, queue_level[12:8]};
      ADDR_QUEUE_LOW:    read_reg = queue_level[7:0];
      ADDR_QUEUE_DATA:   read_reg = queue_rd_data;
      ADDR_IDENTITY:     read_reg = IDENTITY_VALUE;
      ADDR_X_TRIM_HIGH:  read_reg = trimx_q[15:8];
      ADDR_X_TRIM_LOW:   read_reg = trimx_q[7:0];
      ADDR_Y_TRIM_HIGH:  read_reg = trimy_q[15:8];
      ADDR_Y_TRIM_LOW:   read_reg = trimy_q[7:0];
      ADDR_Z_TRIM_HIGH:  read_reg = trimz_q[15:8];
      ADDR_Z_TRIM_LOW:   read_reg = trimz_q[7:0];
      default:           read_reg = RESET_ZERO;
    endcase
  endfunction

  // -----------------------------------------------------------------
  // framing next state
  // -----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    sclk_d  = serial_in.sclk;
    bit_d   = bit_q;
    shift_d = shift_q;
    addr_d  = addr_q;
    read_d  = read_q;
    tx_d    = tx_q;
    sdo_d   = sdo_q;
    oe_n_d  = oe_n_q;
    wr_stb  = 1'b0;
    rd_stb  = 1'b0;
    wr_val  = {shift_q[6:0], serial_in.sdi};
    if (serial_in.cs_n) begin
      state_d = ST_IDLE;
      bit_d   = 3'h0;
      oe_n_d  = 1'b1;
      sdo_d   = 1'b0;
    end else begin
      if (state_q == ST_IDLE) begin
        state_d = ST_ADDR;
      end
      if (rise) begin
        shift_d = wr_val;
        bit_d   = bit_q + 3'h1;
      end
      if (byte_done) begin
        unique case (state_q)
          ST_IDLE, ST_ADDR: begin
            read_d  = wr_val[RW_BIT];
            addr_d  = wr_val[6:0];
            state_d = ST_DATA;
          end
          ST_DATA: begin
            addr_d = addr_q + 7'h1;
            wr_stb = !read_q;
          end
          default: state_d = ST_IDLE;
        endcase
      end
      // fetch at the first fall of a data byte: a prefetch would clear
      // flags or pop the queue for a byte the host never clocks out
      if (fall && state_q == ST_DATA && read_q) begin
        oe_n_d = 1'b0;
        if (bit_q == 3'h0) begin
          tx_d   = read_reg(addr_q);
          sdo_d  = tx_d[7];
          rd_stb = 1'b1;
        end else begin
          sdo_d  = tx_q[3'h7 - bit_q];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      sclk_q  <= 1'b1;
      bit_q   <= 3'h0;
      shift_q <= 8'h00;
      addr_q  <= 7'h00;
      read_q  <= 1'b0;
      tx_q    <= 8'h00;
      sdo_q   <= 1'b0;
      oe_n_q  <= 1'b1;
    end else begin
      state_q <= state_d;
      sclk_q  <= sclk_d;
      bit_q   <= bit_d;
      shift_q <= shift_d;
      addr_q  <= addr_d;
      read_q  <= read_d;
      tx_q    <= tx_d;
      sdo_q   <= sdo_d;
      oe_n_q  <= oe_n_d;
    end
  end

  // -----------------------------------------------------------------
  // register next state
  // -----------------------------------------------------------------
  logic       asleep;
  logic [6:0] cur_addr;
  logic       rd_flags;
  assign asleep   = pwr1_q[POWER_SLEEP_BIT];
  assign cur_addr = addr_q;
  assign rd_flags = rd_stb && cur_addr == ADDR_INT_FLAGS;

  always_comb begin
    pin_d    = pin_q;
    mask_d   = mask_q;
    path_d   = path_q;
    motion_d = motion_q;
    host_d   = host_q;
    pwr1_d   = pwr1_q;
    pwr2_d   = pwr2_q;
    selfx_d  = selfx_q;
    selfy_d  = selfy_q;
    selfz_d  = selfz_q;
    trimx_d  = trimx_q;
    trimy_d  = trimy_q;
    trimz_d  = trimz_q;
    // results change only between frames so a pair never tears
    held_d   = sample_valid ? sample : held_q;
    fresh_d  = sample_valid | fresh_q;
    data_d   = data_q;
    if (serial_in.cs_n && fresh_q) begin
      data_d  = held_q;
      fresh_d = sample_valid;
    end
    loaded_d = 1'b1;
    qrd_d    = rd_stb && cur_addr == ADDR_QUEUE_DATA;
    qwr_d    = 1'b0;
    qwd_d    = qwd_q;
    // flag clear on read; new events win over the clear
    flags_d  = (rd_flags ? 8'h00 : flags_q)
             | (event_flags & INT_FLAG_MASK);
    if (!loaded_q) begin
      selfx_d = factory.self_x;
      selfy_d = factory.self_y;
      selfz_d = factory.self_z;
      trimx_d = factory.trim_x;
      trimy_d = factory.trim_y;
      trimz_d = factory.trim_z;
    end else if (wr_stb) begin
      // while asleep only pin setup, mask and power registers take writes
      unique case (addr_q)
        ADDR_INT_PIN:     pin_d  = wr_val;
        ADDR_INT_MASK:    mask_d = wr_val;
        ADDR_POWER_PRI:   pwr1_d = wr_val;
        ADDR_POWER_STBY:  pwr2_d = wr_val;
        ADDR_SELF_TEST_X: if (!asleep) selfx_d = wr_val;
        ADDR_SELF_TEST_Y: if (!asleep) selfy_d = wr_val;
        ADDR_SELF_TEST_Z: if (!asleep) selfz_d = wr_val;
        ADDR_PATH_CLEAR:  if (!asleep) path_d = wr_val;
        ADDR_MOTION_CTRL: if (!asleep) motion_d = wr_val;
        ADDR_HOST_CTRL:   if (!asleep) host_d = wr_val;
        ADDR_QUEUE_DATA:  if (!asleep) begin
          qwr_d = 1'b1;
          qwd_d = wr_val;
        end
        ADDR_X_TRIM_HIGH: if (!asleep) trimx_d[15:8] = wr_val;
        ADDR_X_TRIM_LOW:  if (!asleep) trimx_d[7:0] = wr_val;
        ADDR_Y_TRIM_HIGH: if (!asleep) trimy_d[15:8] = wr_val;
        ADDR_Y_TRIM_LOW:  if (!asleep) trimy_d[7:0] = wr_val;
        ADDR_Z_TRIM_HIGH: if (!asleep) trimz_d[15:8] = wr_val;
        ADDR_Z_TRIM_LOW:  if (!asleep) trimz_d[7:0] = wr_val;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_q    <= RESET_ZERO;
      mask_q   <= RESET_ZERO;
      flags_q  <= RESET_ZERO;
      path_q   <= RESET_ZERO;
      motion_q <= RESET_ZERO;
      host_q   <= RESET_ZERO;
      pwr1_q   <= RESET_POWER_PRI;
      pwr2_q   <= RESET_ZERO;
      selfx_q  <= RESET_ZERO;
      selfy_q  <= RESET_ZERO;
      selfz_q  <= RESET_ZERO;
      trimx_q  <= 16'h0000;
      trimy_q  <= 16'h0000;
      trimz_q  <= 16'h0000;
      data_q   <= '0;
      held_q   <= '0;
      fresh_q  <= 1'b0;
      loaded_q <= 1'b0;
      qrd_q    <= 1'b0;
      qwr_q    <= 1'b0;
      qwd_q    <= RESET_ZERO;
    end else begin
      pin_q    <= pin_d;
      mask_q   <= mask_d;
      flags_q  <= flags_d;
      path_q   <= path_d;
      motion_q <= motion_d;
      host_q   <= host_d;
      pwr1_q   <= pwr1_d;
      pwr2_q   <= pwr2_d;
      selfx_q  <= selfx_d;
      selfy_q  <= selfy_d;
      selfz_q  <= selfz_d;
      trimx_q  <= trimx_d;
      trimy_q  <= trimy_d;
      trimz_q  <= trimz_d;
      data_q   <= data_d;
      held_q   <= held_d;
      fresh_q  <= fresh_d;
      loaded_q <= loaded_d;
      qrd_q    <= qrd_d;
      qwr_q    <= qwr_d;
      qwd_q    <= qwd_d;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign sdo_out        = sdo_q;
  assign sdo_oe_n       = oe_n_q;
  assign int_mask_out   = mask_q;
  assign power_pri_out  = pwr1_q;
  assign queue_rd_pulse = qrd_q;
  assign queue_wr_pulse = qwr_q;
  assign queue_wr_data  = qwd_q;

endmodule
`default_nettype wire

//--- rtl/accel_regs_pkg.sv
// constants and carrier types for the accelerometer register bank
// assumes a 7-bit register address space reached over a four-wire serial port
package accel_regs_pkg;

  // -----------------------------------------------------------------
  // register offsets
  // -----------------------------------------------------------------
  localparam logic [6:0] ADDR_SELF_TEST_X  = 7'h0d;
  localparam logic [6:0] ADDR_SELF_TEST_Y  = 7'h0e;
  localparam logic [6:0] ADDR_SELF_TEST_Z  = 7'h0f;
  localparam logic [6:0] ADDR_INT_PIN      = 7'h37;
  localparam logic [6:0] ADDR_INT_MASK     = 7'h38;
  localparam logic [6:0] ADDR_INT_FLAGS    = 7'h3a;
  localparam logic [6:0] ADDR_ACCEL_X_HIGH = 7'h3b;
  localparam logic [6:0] ADDR_ACCEL_X_LOW  = 7'h3c;
  localparam logic [6:0] ADDR_ACCEL_Y_HIGH = 7'h3d;
  localparam logic [6:0] ADDR_ACCEL_Y_LOW  = 7'h3e;
  localparam logic [6:0] ADDR_ACCEL_Z_HIGH = 7'h3f;
  localparam logic [6:0] ADDR_ACCEL_Z_LOW  = 7'h40;
  localparam logic [6:0] ADDR_TEMP_HIGH    = 7'h41;
  localparam logic [6:0] ADDR_TEMP_LOW     = 7'h42;
  localparam logic [6:0] ADDR_PATH_CLEAR   = 7'h68;
  localparam logic [6:0] ADDR_MOTION_CTRL  = 7'h69;
  localparam logic [6:0] ADDR_HOST_CTRL    = 7'h6a;
  localparam logic [6:0] ADDR_POWER_PRI    = 7'h6b;
  localparam logic [6:0] ADDR_POWER_STBY   = 7'h6c;
  localparam logic [6:0] ADDR_QUEUE_HIGH   = 7'h72;
  localparam logic [6:0] ADDR_QUEUE_LOW    = 7'h73;
  localparam logic [6:0] ADDR_QUEUE_DATA   = 7'h74;
  localparam logic [6:0] ADDR_IDENTITY     = 7'h75;
  localparam logic [6:0] ADDR_X_TRIM_HIGH  = 7'h77;
  localparam logic [6:0] ADDR_X_TRIM_LOW   = 7'h78;
  localparam logic [6:0] ADDR_Y_TRIM_HIGH  = 7'h7a;
  localparam logic [6:0] ADDR_Y_TRIM_LOW   = 7'h7b;
  localparam logic [6:0] ADDR_Z_TRIM_HIGH  = 7'h7d;
  localparam logic [6:0] ADDR_Z_TRIM_LOW   = 7'h7e;

  // -----------------------------------------------------------------
  // reset values and field positions
  // -----------------------------------------------------------------
  localparam logic [7:0] RESET_ZERO        = 8'h00;
  localparam logic [7:0] RESET_POWER_PRI   = 8'h01;
  localparam int         POWER_SLEEP_BIT   = 6;
  localparam int         RW_BIT            = 7;
  localparam int         INT_RD_CLEAR_BIT  = 4;
  localparam logic [7:0] INT_FLAG_MASK     = 8'he9;

  // -----------------------------------------------------------------
  // carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
    logic [15:0] temp;
  } sample_t;

  typedef struct packed {
    logic [7:0] self_x;
    logic [7:0] self_y;
    logic [7:0] self_z;
    logic [15:0] trim_x;
    logic [15:0] trim_y;
    logic [15:0] trim_z;
  } factory_t;

  typedef struct packed {
    logic        sclk;
    logic        cs_n;
    logic        sdi;
  } serial_in_t;

endpackage

//--- verif/accel_bank_checker.sv
// port checks for the accelerometer register bank
// assumes rst held two cycles whenever it is raised
`timescale 1ns/1ns
`default_nettype none
module accel_bank_checker
  import accel_regs_pkg::*;
(
  // clock and reset
  input wire logic                       clk,
  input wire logic                       rst,
  // watched ports
  input wire accel_regs_pkg::serial_in_t serial_in,
  input wire logic                       sdo_out,
  input wire logic                       sdo_oe_n,
  input wire logic [7:0]                 int_mask_out,
  input wire logic [7:0]                 power_pri_out,
  input wire logic                       queue_rd_pulse,
  input wire logic                       queue_wr_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ------
  // cycles since deselect; a write lands well inside eight
  // ------
  logic [3:0] idle_q, idle_d;
  always_comb begin
    idle_d = idle_q + 4'h1;
    if (rst || !serial_in.cs_n) idle_d = 4'h0;
    else if (idle_q == 4'hf) idle_d = idle_q;
  end
  always_ff @(posedge clk) idle_q <= idle_d;

  a_reset_quiet: assert property (
    $fell(rst) |-> sdo_oe_n && !queue_rd_pulse && !queue_wr_pulse)
    else $error("outputs active after reset");
  a_reset_mask: assert property (
    $fell(rst) |-> int_mask_out == RESET_ZERO)
    else $error("mask not cleared by reset");
  a_reset_power: assert property (
    $fell(rst) |-> power_pri_out == RESET_POWER_PRI)
    else $error("power register reset value wrong");
  a_oe_deselect: assert property (
    $past(serial_in.cs_n) |-> sdo_oe_n)
    else $error("data out enabled while deselected");
  a_sdo_hold: assert property (
    (serial_in.sclk [*3]) ##0 !sdo_oe_n |-> $stable(sdo_out))
    else $error("data out moved while serial clock high");
  a_rd_single: assert property (
    queue_rd_pulse |=> !queue_rd_pulse)
    else $error("queue read pulse too long");
  a_wr_single: assert property (
    queue_wr_pulse |=> !queue_wr_pulse)
    else $error("queue write pulse too long");
  a_idle_quiet: assert property (
    idle_q >= 4'h8 |-> $stable(int_mask_out) && $stable(power_pri_out)
      && !queue_wr_pulse && !queue_rd_pulse)
    else $error("control changed with no frame");
endmodule

bind accel_register_bank accel_bank_checker chk (.clk(clk), .rst(rst),
  .serial_in(serial_in), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
  .int_mask_out(int_mask_out), .power_pri_out(power_pri_out),
  .queue_rd_pulse(queue_rd_pulse), .queue_wr_pulse(queue_wr_pulse));
`default_nettype wire

//--- verif/accel_register_bank_tb.sv
// self-checking bench for the accelerometer register bank
// assumes spi_host as the serial host and the bound port checker
`timescale 1ns/1ns
`default_nettype none
module accel_register_bank_tb;
  import accel_regs_pkg::*;
  localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary value
  logic       clk, rst, sample_valid, sdo_out, sdo_oe_n, rd_p, wr_p;
  logic [7:0] event_flags, queue_rd_data, wr_data, mask, power, flags_m;
  logic [7:0] wlog[$];
  logic [12:0] queue_level;
  logic [95:0] r96;
  logic [6:0] fa[9] = '{7'h0d, 7'h0e, 7'h0f, 7'h77, 7'h78, 7'h7a, 7'h7b,
                        7'h7d, 7'h7e};
  logic [6:0] za[8] = '{7'h37, 7'h38, 7'h3a, 7'h68, 7'h69, 7'h6a, 7'h6c,
                        7'h10};
  sample_t    sample;
  sample_t    cap;
  factory_t   factory;
  serial_in_t serial_in;
  int         seed, fails, cmp_count, rd_cnt, mdl[128];
  accel_register_bank #(.IDENTITY_VALUE(ID_VAL)) dut (.clk(clk), .rst(rst),
    .serial_in(serial_in), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
    .sample(sample), .sample_valid(sample_valid), .event_flags(event_flags),
    .queue_level(queue_level), .queue_rd_data(queue_rd_data),
    .factory(factory), .int_mask_out(mask), .power_pri_out(power),
    .queue_rd_pulse(rd_p), .queue_wr_pulse(wr_p), .queue_wr_data(wr_data));
  spi_host host (.clk(clk), .serial_in(serial_in), .sdo_out(sdo_out),
    .sdo_oe_n(sdo_oe_n));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wr_p === 1'b1) wlog.push_back(wr_data);
    if (rd_p === 1'b1) rd_cnt++;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] exp_rd(input logic [6:0] a);
    if (a >= 7'h3b && a <= 7'h42) return cap[63 - 8 * (a - 7'h3b) -: 8];
    case (a)
      7'h3a: return flags_m;
      7'h72: return {3'h0, queue_level[12:8]};
      7'h73: return queue_level[7:0];
      7'h74: return queue_rd_data;
      7'h75: return ID_VAL;
      default: return 8'(mdl[a]);
    endcase
  endfunction
  task automatic mdl_reset();
    foreach (mdl[k]) mdl[k] = 0;
    mdl[7'h6b] = 1;
    foreach (fa[k]) mdl[fa[k]] = int'(factory[71 - 8 * k -: 8]);
    flags_m = 8'h00;
    cap = '0;
  endtask
  task automatic rd(input logic [6:0] a, input int n);
    host.tx_q.delete();
    repeat (n) host.tx_q.push_back(8'($random(seed)));
    host.xfer({1'b1, a});
    check(8'(host.rx_q.size()), 8'(n));
    foreach (host.rx_q[k]) begin
      check(host.rx_q[k], exp_rd(a + 7'(k)));
      if (a + 7'(k) == 7'h3a) flags_m = 8'h00;
    end
  endtask
  // sends d[7:0] alone, or d[15:8] then d[7:0] as a burst
  task automatic wr(input logic [6:0] a, input logic [15:0] d, input int n);
    logic [6:0] b;
    host.tx_q.delete();
    if (n == 2) host.tx_q.push_back(d[15:8]);
    host.tx_q.push_back(d[7:0]);
    host.xfer({1'b0, a});
    for (int k = 0; k < n; k++) begin
      b = a + 7'(k);
      if (b inside {[7'h0d:7'h0f], 7'h37, 7'h38, [7'h68:7'h6c], 7'h77, 7'h78,
          7'h7a, 7'h7b, 7'h7d, 7'h7e} && ((mdl[7'h6b] & 64) == 0 ||
          b inside {7'h37, 7'h38, 7'h6b, 7'h6c}))
        mdl[b] = int'((n == 2 && k == 0) ? d[15:8] : d[7:0]);
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    mdl_reset();
    repeat (2) @(negedge clk);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #5000000;
    fails++;
    complete_run();
  end
  initial begin
    seed = 91;
    r96 = {$random(seed), $random(seed), $random(seed)};
    factory = r96[71:0];
    sample = {$random(seed), $random(seed)};
    sample_valid = 1'b0;
    event_flags = 8'h00;
    queue_level = 13'h0000;
    queue_rd_data = 8'h00;
    do_reset();
    check(power, 8'h01);
    foreach (fa[k]) rd(fa[k], 1);
    foreach (za[k]) rd(za[k], 1);
    rd(7'h6b, 1);
    sample = {$random(seed), $random(seed)};
    cap = sample;
    sample_valid = 1'b1;
    @(negedge clk);
    sample_valid = 1'b0;
    rd(7'h3b, 8);
    queue_level = 13'($random(seed));
    queue_rd_data = 8'($random(seed));
    rd(7'h72, 4);
    check(8'(rd_cnt), 8'h01);
    wr(7'h37, 16'($random(seed)), 2);
    check(mask, 8'(mdl[7'h38]));
    rd(7'h37, 2);
    wr(7'h74, 16'h00a5, 1);
    check(8'(wlog.size()), 8'h01);
    check(wlog[0], 8'ha5);
    wr(7'h3b, 16'h00aa, 1);
    rd(7'h3b, 1);
    event_flags = 8'hff;
    flags_m = INT_FLAG_MASK;
    @(negedge clk);
    event_flags = 8'h00;
    rd(7'h3a, 1);
    rd(7'h3a, 1);
    wr(7'h6b, 16'h0040, 1);
    wr(7'h6a, 16'h0055, 1);
    wr(7'h38, 16'h0012, 1);
    rd(7'h6a, 1);
    check(mask, 8'h12);
    check(power, 8'h40);
    wr(7'h6b, 16'h0001, 1);
    do_reset();
    check(mask, 8'h00);
    rd(7'h0d, 3);
    rd(7'h3b, 8);
    complete_run();
  end
endmodule
`default_nettype wire

//--- verif/spi_host.sv
// serial host model: frames bytes from tx_q, collects answers in rx_q
// assumes clk is the bank clock; serial clock idles high between frames
`timescale 1ns/1ns
`default_nettype none
module spi_host
  import accel_regs_pkg::*;
(
  input  wire logic                      clk,
  output var accel_regs_pkg::serial_in_t serial_in,
  input  wire logic                      sdo_out,
  input  wire logic                      sdo_oe_n
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  initial serial_in = 3'b110;
  // three clocks each phase: the bank needs at least one
  task automatic shift(input logic [7:0] wb, output logic [7:0] rb);
    for (int i = 7; i >= 0; i--) begin
      @(negedge clk);
      serial_in.sclk = 1'b0;
      serial_in.sdi  = wb[i];
      repeat (3) @(negedge clk);
      rb[i] = sdo_oe_n ? 1'bx : sdo_out;
      serial_in.sclk = 1'b1;
      repeat (2) @(negedge clk);
    end
  endtask
  task automatic xfer(input logic [7:0] hdr);
    logic [7:0] rb;
    rx_q.delete();
    @(negedge clk);
    serial_in.cs_n = 1'b0;
    shift(hdr, rb);
    foreach (tx_q[k]) begin
      shift(tx_q[k], rb);
      rx_q.push_back(rb);
    end
    repeat (3) @(negedge clk);
    serial_in.cs_n = 1'b1;
    // released line must not keep its last value
    serial_in.sdi = ~serial_in.sdi;
    repeat (2) @(negedge clk);
  endtask
endmodule
`default_nettype wire
